/* core/ocr_dev.sv */
// Operand cache end: RAM mode, aliasing, index mode, line operations, prefetch and write-through buffer.
`include "ocr_cfg.svh"
module ocr_dev
  import ocr_pkg::*;
#(
  parameter bit TWO_WAY = 1'b1,
  parameter int RAM_QW  = 2048,
  parameter int LINES   = 512,
  parameter int TAG_W   = 19
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST,
  ocr_if.dev               bus,
  input  wire logic        I_MEM_DONE,
  output logic             O_MEM_WR,
  output logic [31:0]      O_MEM_ADDR,
  output logic [63:0]      O_MEM_WDATA,
  output logic [7:0]       O_MEM_BE,
  output logic             O_FILL_REQ,
  output logic             O_WB_REQ,
  output logic [31:0]      O_LINE_ADDR
);

  localparam int QW_W  = $clog2(RAM_QW);
  localparam int IDX_W = $clog2(LINES);

  typedef struct packed {
    logic                            ack;
    logic                            err;
    logic [63:0]                     rdata;
    logic                            mem_wr;
    logic [31:0]                     mem_addr;
    logic [63:0]                     mem_wdata;
    logic [7:0]                      mem_be;
    logic                            fill_req;
    logic                            wb_req;
    logic [31:0]                     line_addr;
    logic [LINES-1:0]                valid;
    logic [LINES-1:0]                dirty;
    logic [LINES-1:0][TAG_W-1:0]     tag;
    logic [RAM_QW-1:0][63:0]         ram;
  } ocr_dev_s;

  ocr_dev_s s_ff;
  ocr_dev_s nxt_s;

  logic              ram_sel;
  logic              combo_bad;
  logic [QW_W-1:0]   qidx;
  logic [IDX_W-1:0]  lidx;
  logic [TAG_W-1:0]  ltag;
  logic              line_hit;
  logic              oc_on;
  logic [7:0]        be;
  logic              wtb_free;

  // Byte lanes of a quadword touched by an access of the given size.
  function automatic logic [7:0] ocr_lanes(input ocr_size_e sz, input logic [2:0] a);
    logic [7:0] m;
    m = 8'h00;
    case (sz)
      OCR_SZ_BYTE: m = 8'h01 << a;
      OCR_SZ_WORD: m = 8'h03 << {a[2:1], 1'b0};
      OCR_SZ_LONG: m = 8'h0F << {a[2], 2'b00};
      default:     m = 8'hFF;
    endcase
    return m;
  endfunction : ocr_lanes

  // Decode of the RAM window, area aliasing and the cache line index.
  always_comb begin
    oc_on     = bus.operand_cache_enable_bit;
    combo_bad = TWO_WAY && bus.ram_mode_enable && bus.operand_index_mode_bit;
    ram_sel   = oc_on && bus.ram_mode_enable && !combo_bad &&
                (bus.addr[`OCR_RAM_TAG_HI:`OCR_RAM_TAG_LO] == `OCR_RAM_TAG);
    qidx      = '0;
    if (!TWO_WAY && !bus.operand_index_mode_bit) begin
      // Area taken from bit 13 gives the 1,1,2,2 pattern of 4 KB windows.
      qidx = QW_W'({bus.addr[`OCR_AREA_BIT], bus.addr[`OCR_Q_HI_4K:`OCR_Q_LO]});
    end else if (!TWO_WAY) begin
      qidx = QW_W'({bus.addr[`OCR_IDX_MODE_BIT], bus.addr[`OCR_Q_HI_4K:`OCR_Q_LO]});
    end else if (!bus.cache_enhanced_mode_bit) begin
      qidx = QW_W'(bus.addr[`OCR_Q_HI_8K:`OCR_Q_LO]);
    end else begin
      // Bit 13 selects way 0 (area 1) or way 1 (area 2) in 8 KB steps.
      qidx = QW_W'({bus.addr[`OCR_AREA_BIT], bus.addr[`OCR_Q_HI_8K:`OCR_Q_LO]});
    end
    if (bus.operand_index_mode_bit) begin
      lidx = IDX_W'({bus.addr[`OCR_IDX_MODE_BIT], bus.addr[`OCR_NIX_HI:`OCR_LINE_LO]});
    end else begin
      lidx = IDX_W'(bus.addr[`OCR_LINE_HI:`OCR_LINE_LO]);
    end
    // Entries lent to RAM are steered away so the rest stay ordinary cache lines.
    if (bus.ram_mode_enable && !TWO_WAY) begin
      lidx[`OCR_ORIG_RAM_BIT] = 1'b0;
    end else if (bus.ram_mode_enable) begin
      lidx[`OCR_TWAY_RAM_BIT] = 1'b0;
    end
    ltag     = TAG_W'(bus.addr[`OCR_TAG_HI:`OCR_TAG_LO]);
    line_hit = oc_on && s_ff.valid[lidx] && (s_ff.tag[lidx] == ltag);
    be       = ocr_lanes(bus.size, bus.addr[2:0]);
    wtb_free = !s_ff.mem_wr || I_MEM_DONE;
  end

  // Next state: one request is served per handshake, answered by a one-cycle ack or err.
  always_comb begin
    nxt_s          = s_ff;
    nxt_s.ack      = 1'b0;
    nxt_s.err      = 1'b0;
    nxt_s.fill_req = 1'b0;
    nxt_s.wb_req   = 1'b0;
    if (s_ff.mem_wr && I_MEM_DONE) begin
      nxt_s.mem_wr = 1'b0;
    end
    if (bus.req && !s_ff.ack && !s_ff.err) begin
      case (bus.op)
        OCR_OP_LOAD: begin
          // Reads return the whole quadword; the core picks its lanes.
          nxt_s.rdata = ram_sel ? s_ff.ram[qidx] : 64'h0;
          nxt_s.ack   = 1'b1;
        end
        OCR_OP_FETCH: begin
          nxt_s.err = ram_sel;
          nxt_s.ack = !ram_sel;
        end
        OCR_OP_STORE: begin
          if (ram_sel) begin
            for (int b = 0; b < 8; b++) begin
              if (be[b]) begin
                nxt_s.ram[qidx][b*8 +: 8] = bus.wdata[b*8 +: 8];
              end
            end
            nxt_s.ack = 1'b1;
          end else if (!bus.cacheable || bus.wthru || !oc_on) begin
            // A full buffer stalls the core until external memory takes the old word.
            if (wtb_free) begin
              nxt_s.mem_wr    = 1'b1;
              nxt_s.mem_addr  = bus.addr;
              nxt_s.mem_wdata = bus.wdata;
              nxt_s.mem_be    = be;
              nxt_s.ack       = 1'b1;
            end
          end else begin
            nxt_s.ack = 1'b1;
          end
        end
        OCR_OP_PREFETCH_OP: begin
          // Hits, translation misses and violations finish quietly with no fill.
          if (oc_on && !ram_sel && !line_hit && !bus.tlb_miss && !bus.prot_viol && bus.cacheable) begin
            nxt_s.fill_req    = 1'b1;
            nxt_s.line_addr   = bus.addr;
            nxt_s.valid[lidx] = 1'b1;
            nxt_s.dirty[lidx] = 1'b0;
            nxt_s.tag[lidx]   = ltag;
          end
          nxt_s.ack = 1'b1;
        end
        OCR_OP_INVAL: begin
          if (line_hit && !ram_sel) begin
            nxt_s.valid[lidx] = 1'b0;
          end
          nxt_s.ack = 1'b1;
        end
        OCR_OP_PURGE: begin
          if (line_hit && !ram_sel) begin
            nxt_s.wb_req      = s_ff.dirty[lidx];
            nxt_s.line_addr   = bus.addr;
            nxt_s.valid[lidx] = 1'b0;
            nxt_s.dirty[lidx] = 1'b0;
          end
          nxt_s.ack = 1'b1;
        end
        OCR_OP_WBACK: begin
          if (line_hit && !ram_sel) begin
            nxt_s.wb_req      = s_ff.dirty[lidx];
            nxt_s.line_addr   = bus.addr;
            nxt_s.dirty[lidx] = 1'b0;
          end
          nxt_s.ack = 1'b1;
        end
        OCR_OP_ALLOC: begin
          // Allocation claims the line without fetching it; the line is then dirty.
          if (oc_on && !ram_sel && bus.cacheable) begin
            nxt_s.valid[lidx] = 1'b1;
            nxt_s.dirty[lidx] = 1'b1;
            nxt_s.tag[lidx]   = ltag;
          end else if (ram_sel) begin
            nxt_s.ram[qidx] = bus.wdata;
          end
          nxt_s.ack = 1'b1;
        end
        default: begin
          nxt_s.err = 1'b1;
        end
      endcase
    end
  end

  // State register; lines come up invalid and clean.
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Outputs straight from the state register.
  assign bus.ack     = s_ff.ack;
  assign bus.err     = s_ff.err;
  assign bus.rdata   = s_ff.rdata;
  assign O_MEM_WR    = s_ff.mem_wr;
  assign O_MEM_ADDR  = s_ff.mem_addr;
  assign O_MEM_WDATA = s_ff.mem_wdata;
  assign O_MEM_BE    = s_ff.mem_be;
  assign O_FILL_REQ  = s_ff.fill_req;
  assign O_WB_REQ    = s_ff.wb_req;
  assign O_LINE_ADDR = s_ff.line_addr;

endmodule : ocr_dev

/* core/ocr_host.sv */
// Load/store pipeline end: software registers that drive requests to the operand cache end.
`include "ocr_cfg.svh"
module ocr_host
  import ocr_pkg::*;
#(
  parameter bit TWO_WAY = 1'b1
) (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RST,
  ocr_if.host              bus,
  input  wire logic [3:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic [31:0]      O_RDATA,
  output logic             O_EXC_BLOCK
);

  typedef struct packed {
    logic [3:0]  ctrl;
    logic [31:0] addr;
    logic [63:0] wdata;
    logic [9:0]  cmd;
    logic        req;
    logic        busy;
    logic        err;
    logic        refused;
    logic [63:0] rd;
    logic [31:0] rdata;
    logic [2:0]  blk;
    logic        exc;
  } ocr_host_s;

  ocr_host_s s_ff;
  ocr_host_s nxt_s;
  logic      ram_addr;
  logic      is_store;

  // Register access, request launch and completion.
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.rdata = 32'h0;
    ram_addr    = s_ff.ctrl[`OCR_CTRL_ORA] && (I_WDATA[`OCR_CMD_OP_HI:`OCR_CMD_OP_LO] != 4'(OCR_OP_FETCH)) &&
                  (s_ff.addr[`OCR_RAM_TAG_HI:`OCR_RAM_TAG_LO] == `OCR_RAM_TAG);
    is_store    = (I_WDATA[`OCR_CMD_OP_HI:`OCR_CMD_OP_LO] == 4'(OCR_OP_STORE)) ||
                  (I_WDATA[`OCR_CMD_OP_HI:`OCR_CMD_OP_LO] == 4'(OCR_OP_ALLOC));
    if (s_ff.busy && bus.ack) begin
      nxt_s.busy = 1'b0;
      nxt_s.req  = 1'b0;
      nxt_s.rd   = bus.rdata;
    end
    if (s_ff.busy && bus.err) begin
      nxt_s.busy = 1'b0;
      nxt_s.req  = 1'b0;
      nxt_s.err  = 1'b1;
    end
    if (I_RD) begin
      if (I_ADDR == `OCR_REG_CTRL) begin
        nxt_s.rdata = {28'h0, s_ff.ctrl};
      end else if (I_ADDR == `OCR_REG_ADDR) begin
        nxt_s.rdata = s_ff.addr;
      end else if (I_ADDR == `OCR_REG_STAT) begin
        nxt_s.rdata = {28'h0, s_ff.exc, s_ff.refused, s_ff.err, s_ff.busy};
      end else if (I_ADDR == `OCR_REG_RDLO) begin
        nxt_s.rdata = s_ff.rd[31:0];
      end else if (I_ADDR == `OCR_REG_RDHI) begin
        nxt_s.rdata = s_ff.rd[63:32];
      end
    end
    if (I_WR) begin
      if (I_ADDR == `OCR_REG_CTRL) begin
        nxt_s.ctrl = I_WDATA[3:0];
        if (TWO_WAY && I_WDATA[`OCR_CTRL_ORA]) begin
          nxt_s.ctrl[`OCR_CTRL_OIX] = 1'b0;
        end
      end else if (I_ADDR == `OCR_REG_ADDR) begin
        nxt_s.addr = I_WDATA;
      end else if (I_ADDR == `OCR_REG_WDLO) begin
        nxt_s.wdata[31:0] = I_WDATA;
      end else if (I_ADDR == `OCR_REG_WDHI) begin
        nxt_s.wdata[63:32] = I_WDATA;
      end else if (I_ADDR == `OCR_REG_CMD && !s_ff.busy) begin
        // Line operations go out only on command; nothing is issued on its own.
        nxt_s.err     = 1'b0;
        nxt_s.refused = TWO_WAY && s_ff.ctrl[`OCR_CTRL_EMODE] && ram_addr && is_store &&
                        s_ff.addr[`OCR_AREA_BIT];
        if (!nxt_s.refused) begin
          nxt_s.cmd  = I_WDATA[9:0];
          nxt_s.req  = 1'b1;
          nxt_s.busy = 1'b1;
          // Exceptions stay blocked over a RAM-window access other than a fetch and the next three commands.
          if (ram_addr) begin
            nxt_s.blk = `OCR_BLK_CNT;
          end else if (s_ff.blk != 3'h0) begin
            nxt_s.blk = s_ff.blk - 3'h1;
          end
        end
      end
    end
    nxt_s.exc = (nxt_s.blk != 3'h0);
  end

  // State register.
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // Link and port outputs from the state register.
  assign bus.req                      = s_ff.req;
  assign bus.op                       = ocr_op_e'(s_ff.cmd[`OCR_CMD_OP_HI:`OCR_CMD_OP_LO]);
  assign bus.size                     = ocr_size_e'(s_ff.cmd[`OCR_CMD_SZ_HI:`OCR_CMD_SZ_LO]);
  assign bus.cacheable                = s_ff.cmd[`OCR_CMD_CACHE];
  assign bus.wthru                    = s_ff.cmd[`OCR_CMD_WTHRU];
  assign bus.tlb_miss                 = s_ff.cmd[`OCR_CMD_TLBMISS];
  assign bus.prot_viol                = s_ff.cmd[`OCR_CMD_PROT];
  assign bus.addr                     = s_ff.addr;
  assign bus.wdata                    = s_ff.wdata;
  assign bus.ram_mode_enable          = s_ff.ctrl[`OCR_CTRL_ORA];
  assign bus.operand_index_mode_bit   = s_ff.ctrl[`OCR_CTRL_OIX];
  assign bus.cache_enhanced_mode_bit  = s_ff.ctrl[`OCR_CTRL_EMODE];
  assign bus.operand_cache_enable_bit = s_ff.ctrl[`OCR_CTRL_OCE];
  assign O_RDATA                      = s_ff.rdata;
  assign O_EXC_BLOCK                  = s_ff.exc;

endmodule : ocr_host

/* shared/ocr_cfg.svh */
// Address map, field positions and counts for the operand cache RAM block.
`ifndef OCR_CFG_SVH
`define OCR_CFG_SVH
`define OCR_RAM_TAG      6'h1F
`define OCR_RAM_TAG_HI   31
`define OCR_RAM_TAG_LO   26
`define OCR_IDX_MODE_BIT 25
`define OCR_AREA_BIT     13
`define OCR_TAG_HI       28
`define OCR_TAG_LO       10
`define OCR_LINE_HI      13
`define OCR_LINE_LO      5
`define OCR_NIX_HI       12
`define OCR_Q_HI_4K      11
`define OCR_Q_HI_8K      12
`define OCR_Q_LO         3
`define OCR_ORIG_RAM_BIT 7
`define OCR_TWAY_RAM_BIT 8
`define OCR_REG_CTRL     4'h0
`define OCR_REG_ADDR     4'h1
`define OCR_REG_WDLO     4'h2
`define OCR_REG_WDHI     4'h3
`define OCR_REG_CMD      4'h4
`define OCR_REG_STAT     4'h5
`define OCR_REG_RDLO     4'h6
`define OCR_REG_RDHI     4'h7
`define OCR_CTRL_ORA     0
`define OCR_CTRL_OIX     1
`define OCR_CTRL_EMODE   2
`define OCR_CTRL_OCE     3
`define OCR_CMD_OP_HI    3
`define OCR_CMD_OP_LO    0
`define OCR_CMD_SZ_HI    5
`define OCR_CMD_SZ_LO    4
`define OCR_CMD_CACHE    6
`define OCR_CMD_WTHRU    7
`define OCR_CMD_TLBMISS  8
`define OCR_CMD_PROT     9
`define OCR_BLK_CNT      3'h4
`endif

/* shared/ocr_if.sv */
// Link between the load/store pipeline end and the operand cache end.
interface ocr_if;
  import ocr_pkg::*;
  logic        req;
  ocr_op_e     op;
  logic [31:0] addr;
  ocr_size_e   size;
  logic [63:0] wdata;
  logic        cacheable;
  logic        wthru;
  logic        tlb_miss;
  logic        prot_viol;
  logic        ram_mode_enable;
  logic        operand_index_mode_bit;
  logic        cache_enhanced_mode_bit;
  logic        operand_cache_enable_bit;
  logic        ack;
  logic        err;
  logic [63:0] rdata;
  modport host (output req, op, addr, size, wdata, cacheable, wthru, tlb_miss, prot_viol, ram_mode_enable,
                output operand_index_mode_bit, cache_enhanced_mode_bit, operand_cache_enable_bit,
                input ack, err, rdata);
  modport dev  (input req, op, addr, size, wdata, cacheable, wthru, tlb_miss, prot_viol, ram_mode_enable,
                input operand_index_mode_bit, cache_enhanced_mode_bit, operand_cache_enable_bit,
                output ack, err, rdata);
endinterface : ocr_if

/* shared/ocr_pkg.sv */
// Types shared by both ends of the operand cache RAM block.
package ocr_pkg;
  typedef enum logic [3:0] {
    OCR_OP_LOAD  = 4'h0,
    OCR_OP_STORE = 4'h1,
    OCR_OP_FETCH = 4'h2,
    OCR_OP_PREFETCH_OP  = 4'h3,
    OCR_OP_INVAL = 4'h4,
    OCR_OP_PURGE = 4'h5,
    OCR_OP_WBACK = 4'h6,
    OCR_OP_ALLOC = 4'h7
  } ocr_op_e;
  typedef enum logic [1:0] {
    OCR_SZ_BYTE = 2'h0,
    OCR_SZ_WORD = 2'h1,
    OCR_SZ_LONG = 2'h2,
    OCR_SZ_QUAD = 2'h3
  } ocr_size_e;
endpackage : ocr_pkg

/* test/ocr_checker.sv */
// Concurrent checks on the link between the pipeline end and the two-way operand cache end.
module ocr_checker
  import ocr_pkg::*;
(
  input wire logic        I_SYS_CLK,
  input wire logic        I_RST,
  input wire logic        req,
  input wire ocr_op_e     op,
  input wire logic [31:0] addr,
  input wire logic        ram_mode_enable,
  input wire logic        operand_index_mode_bit,
  input wire logic        operand_cache_enable_bit,
  input wire logic        ack,
  input wire logic        err,
  input wire logic [63:0] rdata
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);

  logic in_ram;

  // The RAM window is decoded only with the cache on, and index mode removes it on this end.
  assign in_ram = addr[31:26] == 6'h1F && ram_mode_enable && operand_cache_enable_bit && !operand_index_mode_bit;

  // A request that the cache end takes at this edge.
  sequence s_taken;
    req && !ack && !err;
  endsequence

  // A taken request aimed at the RAM window.
  sequence s_ram_taken;
    s_taken ##0 in_ram;
  endsequence

  // Response pulses and the request handshake.
  a_ack_single: assert property (ack |=> !ack)
    else $error("ack stood longer than one cycle");
  a_err_single: assert property (err |=> !err)
    else $error("err stood longer than one cycle");
  a_resp_excl: assert property (!(ack && err))
    else $error("ack and err together");
  a_resp_has_req: assert property ((ack || err) |-> req)
    else $error("response without a request");
  a_req_drop: assert property ((ack || err) |=> !req)
    else $error("request kept after its response");
  a_req_hold: assert property (s_taken |=> req && $stable(addr) && $stable(op))
    else $error("request changed while waiting");

  // RAM window accesses.
  a_fetch_refused: assert property (s_ram_taken ##0 (op == OCR_OP_FETCH) |=> err && !ack)
    else $error("fetch from the RAM window not refused");
  a_ram_data_ack: assert property (s_ram_taken ##0 (op inside {OCR_OP_LOAD, OCR_OP_STORE}) |=> ack)
    else $error("RAM data access not answered in one cycle");
  a_rdata_hold: assert property (!$stable(rdata) |-> ack && op == OCR_OP_LOAD)
    else $error("read data changed without a load answer");
endmodule : ocr_checker

/* test/tb_operand_cache_ram_mode.sv */
// Self-checking bench for both ends of the operand cache RAM block, original and two-way variants.
module tb_operand_cache_ram_mode
  import ocr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        I_SYS_CLK;
  logic        I_RST;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [1:0]  reg_wr;
  logic [1:0]  reg_rd;
  logic [1:0]  mem_done;
  logic [31:0] reg_rdata [2];
  logic        mem_wr    [2];
  logic [31:0] mem_addr  [2];
  logic [63:0] mem_wdata [2];
  logic [7:0]  mem_be    [2];
  logic        fill_req  [2];
  logic        wb_req    [2];
  logic        exc_blk   [2];
  logic [31:0] line_addr [2];
  logic [63:0] ram       [2][2048];
  int          errors;
  int          checks_done;
  int          fills;
  int          wbs;
  int          seed;
  logic [3:0]  ctl [4] = '{4'h9, 4'hB, 4'h9, 4'hD};
  logic [31:0] msk [4] = '{32'h00002FF8, 32'h02000FF8, 32'h00001FF8, 32'h00003FF8};
  logic [31:0] pa  [4] = '{32'h0C000100, 32'h0C000100, 32'h0C000200, 32'h0C000300};
  logic [3:0]  pf  [4] = '{4'h1, 4'h1, 4'h5, 4'h9};
  logic [31:0] la  [7] = '{32'h0C001000, 32'h0C001000, 32'h0C002000, 32'h0C002000, 32'h0C002000,
                           32'h0C003000, 32'h0C003000};
  ocr_op_e     lop [7] = '{OCR_OP_ALLOC, OCR_OP_PURGE, OCR_OP_ALLOC, OCR_OP_INVAL, OCR_OP_WBACK,
                           OCR_OP_ALLOC, OCR_OP_WBACK};
  int          lw  [7] = '{0, 1, 1, 1, 1, 1, 2};

  // One pipeline end and one cache end per variant: 0 is the original, 1 the two-way.
  for (genvar g = 0; g < 2; g++) begin : g_pair
    ocr_if lnk ();
    ocr_host #(.TWO_WAY(g == 1)) i_ocr_host (
      .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .bus(lnk.host), .I_ADDR(reg_addr), .I_WDATA(reg_wdata),
      .I_WR(reg_wr[g]), .I_RD(reg_rd[g]), .O_RDATA(reg_rdata[g]), .O_EXC_BLOCK(exc_blk[g]));
    ocr_dev #(.TWO_WAY(g == 1)) i_ocr_dev (
      .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .bus(lnk.dev), .I_MEM_DONE(mem_done[g]), .O_MEM_WR(mem_wr[g]),
      .O_MEM_ADDR(mem_addr[g]), .O_MEM_WDATA(mem_wdata[g]), .O_MEM_BE(mem_be[g]), .O_FILL_REQ(fill_req[g]),
      .O_WB_REQ(wb_req[g]), .O_LINE_ADDR(line_addr[g]));
  end

  // Assertions watch the two-way link.
  ocr_checker i_ocr_checker (
    .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .req(g_pair[1].lnk.req), .op(g_pair[1].lnk.op),
    .addr(g_pair[1].lnk.addr), .ram_mode_enable(g_pair[1].lnk.ram_mode_enable),
    .operand_index_mode_bit(g_pair[1].lnk.operand_index_mode_bit),
    .operand_cache_enable_bit(g_pair[1].lnk.operand_cache_enable_bit),
    .ack(g_pair[1].lnk.ack), .err(g_pair[1].lnk.err), .rdata(g_pair[1].lnk.rdata));

  // The clock toggles every 10 ns.
  initial begin
    I_SYS_CLK = 1'b0;
    forever #10 I_SYS_CLK = ~I_SYS_CLK;
  end

  // Counts fill and write-back pulses of the two-way end.
  always @(posedge I_SYS_CLK) begin
    if (fill_req[1] === 1'b1)
      fills++;
    if (wb_req[1] === 1'b1)
      wbs++;
  end

  // Model of the RAM index that an address selects in each variant and mode.
  function automatic int ram_idx(input int v, input logic [3:0] c, input logic [31:0] a);
    if (v == 0)
      return c[1] ? {a[25], a[11:3]} : {a[13], a[11:3]};
    return c[2] ? {a[13], a[12:3]} : a[12:3];
  endfunction : ram_idx

  function automatic logic [9:0] cmdw(input ocr_op_e op, input ocr_size_e sz, input logic [3:0] fl);
    return {fl, sz, op};
  endfunction : cmdw

  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic reg_write(input int v, input logic [3:0] a, input logic [31:0] d);
    @(posedge I_SYS_CLK);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr[v] <= 1'b1;
    @(posedge I_SYS_CLK);
    reg_wr[v] <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input int v, input logic [3:0] a, output logic [31:0] d);
    @(posedge I_SYS_CLK);
    reg_addr <= a;
    reg_rd[v] <= 1'b1;
    @(posedge I_SYS_CLK);
    reg_rd[v] <= 1'b0;
    #1 d = reg_rdata[v];
  endtask : reg_read

  task automatic launch(input int v, input logic [31:0] a, input logic [63:0] d, input logic [9:0] c);
    reg_write(v, 4'h1, a);
    reg_write(v, 4'h2, d[31:0]);
    reg_write(v, 4'h3, d[63:32]);
    reg_write(v, 4'h4, {22'h0, c});
  endtask : launch

  // Polls the status register until the command is no longer busy, under a bound.
  task automatic settle(input int v, output logic [31:0] st);
    int n;
    n = 0;
    st = 32'h1;
    while (st[0] !== 1'b0 && n < 40) begin
      reg_read(v, 4'h5, st);
      n++;
    end
    check("busy", 64'h0, 64'(st[0]));
  endtask : settle

  task automatic pulse_done;
    @(posedge I_SYS_CLK);
    mem_done[1] <= 1'b1;
    @(posedge I_SYS_CLK);
    mem_done[1] <= 1'b0;
  endtask : pulse_done

  task automatic finish_test;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // Cuts a hung run short.
  initial begin
    repeat (40000) @(posedge I_SYS_CLK);
    errors++;
    finish_test();
  end

  // Main sequence: reset, register checks, RAM aliasing, buffer, refusal, prefetch and line operations.
  initial begin
    int          v;
    int          off;
    logic [31:0] a;
    logic [31:0] a2;
    logic [31:0] st;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [63:0] b;
    logic [63:0] d;
    logic        rf;
    ocr_size_e   sz;
    int          base;
    seed = 60;
    errors = 0;
    checks_done = 0;
    I_RST = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 2'b00;
    reg_rd = 2'b00;
    mem_done = 2'b00;
    for (int i = 0; i < 2048; i++) begin
      ram[0][i] = 64'h0;
      ram[1][i] = 64'h0;
    end
    repeat (12) @(posedge I_SYS_CLK);
    I_RST <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      reg_read(i, 4'h0, st);
      check("ctrl reset", 64'h0, 64'(st));
      reg_read(i, 4'h5, st);
      check("stat reset", 64'h0, 64'(st));
      reg_read(i, 4'hF, st);
      check("unmapped", 64'h0, 64'(st));
    end
    reg_write(1, 4'h0, 32'hB);
    reg_read(1, 4'h0, st);
    check("ctrl", 64'h9, 64'(st));
    for (int c = 0; c < 4; c++) begin
      v = c / 2;
      reg_write(v, 4'h0, {28'h0, ctl[c]});
      for (int k = 0; k < 12; k++) begin
        sz = ocr_size_e'(2'($random(seed)));
        off = $random(seed) & 7 & ~((1 << sz) - 1);
        a = {6'h1F, 23'($random(seed)), 3'(off)};
        a2 = ({6'h1F, 23'($random(seed)), 3'h0} & ~msk[c]) | (a & msk[c]);
        b = {$random(seed), $random(seed)};
        d = sz == OCR_SZ_BYTE ? {8{b[7:0]}} : sz == OCR_SZ_WORD ? {4{b[15:0]}} : sz == OCR_SZ_LONG ? {2{b[31:0]}} : b;
        rf = v == 1 && ctl[c][2] && a[13];
        launch(v, a, d, cmdw(OCR_OP_STORE, sz, 4'h1));
        settle(v, st);
        check("refused", 64'(rf), 64'(st[2]));
        if (!rf) begin
          for (int i = off; i < off + (1 << sz); i++)
            ram[v][ram_idx(v, ctl[c], a)][i*8 +: 8] = d[i*8 +: 8];
          launch(v, a2, 64'h0, cmdw(OCR_OP_LOAD, OCR_SZ_QUAD, 4'h1));
          settle(v, st);
          reg_read(v, 4'h6, lo);
          reg_read(v, 4'h7, hi);
          check("ram load", ram[v][ram_idx(v, ctl[c], a2)], {hi, lo});
        end
      end
    end
    reg_write(1, 4'h0, 32'h1);
    launch(1, 32'h7C000100, 64'h0123456789ABCDEF, cmdw(OCR_OP_STORE, OCR_SZ_QUAD, 4'h1));
    settle(1, st);
    check("exc set", 64'h1, 64'(exc_blk[1]));
    check("buf addr", 64'h7C000100, 64'(mem_addr[1]));
    check("buf data", 64'h0123456789ABCDEF, mem_wdata[1]);
    check("buf be", 64'hFF, 64'(mem_be[1]));
    reg_write(1, 4'h0, 32'h9);
    launch(1, 32'h0C000045, {8{8'h5A}}, cmdw(OCR_OP_STORE, OCR_SZ_BYTE, 4'h3));
    reg_read(1, 4'h5, st);
    check("busy while full", 64'h1, 64'(st[0]));
    pulse_done();
    settle(1, st);
    check("buf addr2", 64'h01800008, 64'(mem_addr[1][31:3]));
    check("buf be2", 64'h20, 64'(mem_be[1]));
    pulse_done();
    repeat (2) @(posedge I_SYS_CLK);
    check("buf empty", 64'h0, 64'(mem_wr[1]));
    for (int i = 0; i < 2; i++) begin
      reg_write(i, 4'h0, 32'h9);
      launch(i, 32'h7C000040, 64'h0, cmdw(OCR_OP_FETCH, OCR_SZ_LONG, 4'h1));
      settle(i, st);
      check("fetch err", 64'h1, 64'(st[1]));
    end
    base = fills;
    for (int i = 0; i < 4; i++) begin
      launch(1, pa[i], 64'h0, cmdw(OCR_OP_PREFETCH_OP, OCR_SZ_QUAD, pf[i]));
      settle(1, st);
      check("prefetch_op err", 64'h0, 64'(st[1]));
      check("fills", 64'h1, 64'(fills - base));
    end
    check("fill addr", 64'h0C000100, 64'(line_addr[1]));
    check("exc clear", 64'h0, 64'(exc_blk[1]));
    base = wbs;
    for (int i = 0; i < 7; i++) begin
      launch(1, la[i], 64'h0, cmdw(lop[i], OCR_SZ_LONG, 4'h1));
      settle(1, st);
      check("writebacks", 64'(lw[i]), 64'(wbs - base));
    end
    check("wb addr", 64'h0C003000, 64'(line_addr[1]));
    finish_test();
  end
endmodule : tb_operand_cache_ram_mode
